/* File: rtl/bss_consts.svh */
// constants for the battery switch and thermal supervisor
// Notes on behaviour
// - soft disconnect on adapter, no charge: switch open, buck off
// - adapter-powered soft disconnect always retries after delay
// - charging soft disconnect: charge off, switch, then buck
// - pin rising edge opens switch, stops charge, buck runs
// - factory boost only when its enable bit is 1
// - pin high holds switch open; host drives it
// - thermal loop change raises interrupt, shows status bit
// - charger ok follows charge details only
// - temperature profile acts only when enabled
// - out of window: suspend, reset timers, report, interrupt
// - back in window: resume charge, restart timer
// - thermistor at supply means battery removed, no charge
// - grounded thermistor: no monitoring, battery assumed, autostart
// - profile disabled ignores hot and cold; thermistor at supply still means no battery
`ifndef BSS_CONSTS_SVH
`define BSS_CONSTS_SVH
// --------------------------------------------------------------------
// charge details codes
// --------------------------------------------------------------------
`define BSS_DTL_OFF 4'h0
`define BSS_DTL_CHARGING 4'h1
`define BSS_DTL_DONE 4'h4
`define BSS_DTL_TEMP_SUSP 4'h5
`define BSS_DTL_TIMEOUT 4'h6
`define BSS_DTL_NO_BATT 4'h7
// --------------------------------------------------------------------
// timing
// --------------------------------------------------------------------
`define BSS_CLK_MHZ 200
`define BSS_RETRY_US 150000
`define BSS_RETRY_CYC (`BSS_RETRY_US * `BSS_CLK_MHZ)
`define BSS_STEP_NS 100
`define BSS_STEP_CYC ((`BSS_STEP_NS * `BSS_CLK_MHZ + 999) / 1000)
`define BSS_CHG_TIMEOUT_CYC 32'h7fffffff
`define BSS_MODE_BOOST 4'h9
`endif

/* File: rtl/bss_pkg.sv */
// types shared by the battery switch and thermal supervisor
package bss_pkg;
	// conditioned comparator flags
	typedef struct packed {
		logic cold;
		logic hot;
		logic thm_removed;
		logic thm_grounded;
		logic sys_up;
		logic charger_input_valid;
		logic tjunc_reg;
	} bss_flags_s;

	typedef enum logic [2:0] {
		ST_RUN,
		ST_CHG_OFF,
		ST_SW_OPEN,
		ST_BUCK_OFF,
		ST_WAIT_LOW,
		ST_RETRY
	} bss_seq_e;
endpackage

/* File: rtl/bss_sync.sv */
// two flip-flop synchroniser for a vector of levels
`timescale 1ns/1ps
module bss_sync #(
	parameter int W = 1
) (
	// clock and reset
	input wire logic clk,
	input wire logic sys_rst,
	// levels
	input wire logic [W-1:0] d,
	output logic [W-1:0] q
);
	logic [W-1:0] meta_r;

	// first stage feeds only the second
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			meta_r <= '0;
			q <= '0;
		end else begin
			meta_r <= d;
			q <= meta_r;
		end
	end
endmodule

/* File: rtl/bss_supervisor.sv */
// battery switch sequencing and thermistor charge supervision
`timescale 1ns/1ps
`include "bss_consts.svh"
module bss_supervisor import bss_pkg::*; #(
	parameter int unsigned RETRY_CYC = `BSS_RETRY_CYC,
	parameter int unsigned TIMEOUT_CYC = `BSS_CHG_TIMEOUT_CYC
) (
	// clock and reset
	input wire logic clk,
	input wire logic sys_rst,
	// host control bits
	input wire logic soft_battery_disconnect,
	input wire logic factory_boost_enable,
	input wire logic temp_profile_enable,
	input wire logic charge_enable,
	input wire logic recycle_enable,
	input wire logic [3:0] mode,
	// host pin, pulled low on the board when undriven
	input wire logic hw_battery_disconnect_pin,
	// analog comparator flags, asynchronous
	input wire bss_flags_s cmp_flags,
	// power stage controls
	output logic battery_system_switch,
	output logic buck_enable,
	output logic charge_active,
	output logic boost_active,
	output logic timer_restart,
	// status
	output logic thermal_regulation_status,
	output logic [3:0] charge_details,
	output logic charger_ok,
	output logic charger_interrupt
);
	initial begin
		if (RETRY_CYC < 1 || TIMEOUT_CYC < 1)
			$error("bss_supervisor: counts must be at least one");
	end

	localparam int unsigned STEP = `BSS_STEP_CYC;

	// ----------------------------------------------------------------
	// input conditioning
	// ----------------------------------------------------------------
	bss_flags_s fl;
	logic pin_s;
	logic pin_d_r;
	bss_sync #(.W($bits(bss_flags_s))) u_sync_flags (
		.clk(clk),
		.sys_rst(sys_rst),
		.d(cmp_flags),
		.q(fl)
	);
	bss_sync #(.W(1)) u_sync_pin (
		.clk(clk),
		.sys_rst(sys_rst),
		.d(hw_battery_disconnect_pin),
		.q(pin_s)
	);

	// edge detect on the synchronised pin
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst)
			pin_d_r <= 1'b0;
		else
			pin_d_r <= pin_s;
	end
	wire pin_rise = pin_s & ~pin_d_r;

	// ----------------------------------------------------------------
	// temperature window decode
	// ----------------------------------------------------------------
	// grounded thermistor disables monitoring and assumes a battery
	wire mon_on = temp_profile_enable & ~fl.thm_grounded;
	wire removed = fl.thm_removed & ~fl.thm_grounded;
	wire temp_bad = mon_on & (fl.cold | fl.hot);

	// ----------------------------------------------------------------
	// soft disconnect sequencer
	// ----------------------------------------------------------------
	bss_seq_e seq_r;
	logic [31:0] cnt_r;
	logic pin_latch_r;

	function automatic logic cnt_done(input logic [31:0] c,
		input int unsigned lim);
		cnt_done = (c >= lim - 1);
	endfunction

	// staged shutdown, charge-off and switch-open steps held STEP cycles so order is visible
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			seq_r <= ST_RUN;
			cnt_r <= '0;
		end else begin
			case (seq_r)
			ST_RUN: begin
				cnt_r <= '0;
				if (soft_battery_disconnect) begin
					if (charge_active)
						seq_r <= ST_CHG_OFF;
					else
						seq_r <= ST_SW_OPEN;
				end
			end
			ST_CHG_OFF: begin
				cnt_r <= cnt_r + 32'h1;
				if (cnt_done(cnt_r, STEP)) begin
					cnt_r <= '0;
					seq_r <= ST_SW_OPEN;
				end
			end
			ST_SW_OPEN: begin
				cnt_r <= cnt_r + 32'h1;
				if (cnt_done(cnt_r, STEP)) begin
					cnt_r <= '0;
					seq_r <= ST_BUCK_OFF;
				end
			end
			ST_BUCK_OFF: begin
				cnt_r <= '0;
				seq_r <= ST_WAIT_LOW;
			end
			ST_WAIT_LOW: begin
				// rail must sit below the up threshold for the delay
				if (fl.sys_up)
					cnt_r <= '0;
				else
					cnt_r <= cnt_r + 32'h1;
				if (!fl.sys_up && cnt_done(cnt_r, RETRY_CYC)) begin
					cnt_r <= '0;
					// adapter powered: retry whatever recycle says
					if (fl.charger_input_valid || recycle_enable)
						seq_r <= ST_RETRY;
				end
			end
			ST_RETRY: begin
				// bit still set would loop forever; wait for release
				cnt_r <= '0;
				if (!soft_battery_disconnect)
					seq_r <= ST_RUN;
			end
			default: seq_r <= ST_RUN;
			endcase
		end
	end

	// pin rising edge latches disconnect until pin falls
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst)
			pin_latch_r <= 1'b0;
		else if (pin_rise)
			pin_latch_r <= 1'b1;
		else if (!pin_s)
			pin_latch_r <= 1'b0;
	end

	wire seq_sw_open = (seq_r == ST_SW_OPEN) || (seq_r == ST_BUCK_OFF)
		|| (seq_r == ST_WAIT_LOW);
	wire seq_chg_off = (seq_r != ST_RUN) && (seq_r != ST_RETRY);
	wire seq_buck_off = (seq_r == ST_BUCK_OFF) || (seq_r == ST_WAIT_LOW);
	wire fboost = factory_boost_enable && (mode == `BSS_MODE_BOOST);

	// ----------------------------------------------------------------
	// charge control and timer
	// ----------------------------------------------------------------
	logic temp_bad_d_r;
	logic [31:0] tmr_r;
	logic timed_out_r;
	wire chg_allow = charge_enable & fl.charger_input_valid & ~removed & ~temp_bad
		& ~seq_chg_off & ~pin_latch_r & ~pin_s & ~fboost;

	// charge timer, reset on suspend and on resume
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			temp_bad_d_r <= 1'b0;
			tmr_r <= '0;
			timed_out_r <= 1'b0;
		end else begin
			temp_bad_d_r <= temp_bad;
			if (temp_bad || (temp_bad_d_r && !temp_bad) || !chg_allow) begin
				tmr_r <= '0;
				if (!charge_enable || !fl.charger_input_valid)
					timed_out_r <= 1'b0;
			end else if (!timed_out_r) begin
				tmr_r <= tmr_r + 32'h1;
				if (cnt_done(tmr_r, TIMEOUT_CYC))
					timed_out_r <= 1'b1;
			end
		end
	end

	// ----------------------------------------------------------------
	// outputs
	// ----------------------------------------------------------------
	logic thermal_regulation_status_d_r;
	logic [3:0] dtl_nxt;

	// details code picks the highest-priority reason
	always_comb begin
		if (!fl.charger_input_valid || !charge_enable)
			dtl_nxt = `BSS_DTL_OFF;
		else if (removed)
			dtl_nxt = `BSS_DTL_NO_BATT;
		else if (temp_bad)
			dtl_nxt = `BSS_DTL_TEMP_SUSP;
		else if (timed_out_r)
			dtl_nxt = `BSS_DTL_TIMEOUT;
		else if (chg_allow)
			dtl_nxt = `BSS_DTL_CHARGING;
		else
			dtl_nxt = `BSS_DTL_OFF;
	end

	// registered power controls
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			battery_system_switch <= 1'b0;
			buck_enable <= 1'b0;
			charge_active <= 1'b0;
			boost_active <= 1'b0;
			timer_restart <= 1'b0;
		end else begin
			// pin or sequencer force the switch open
			battery_system_switch <= ~seq_sw_open & ~pin_s & ~pin_latch_r
				& ~fboost;
			// pin does not stop the buck
			buck_enable <= fl.charger_input_valid & ~seq_buck_off;
			charge_active <= chg_allow & ~timed_out_r;
			boost_active <= fboost;
			timer_restart <= temp_bad_d_r & ~temp_bad;
		end
	end

	// status and interrupt pulse
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			thermal_regulation_status_d_r <= 1'b0;
			thermal_regulation_status <= 1'b0;
			charge_details <= `BSS_DTL_OFF;
			charger_ok <= 1'b0;
			charger_interrupt <= 1'b0;
		end else begin
			thermal_regulation_status_d_r <= fl.tjunc_reg;
			thermal_regulation_status <= fl.tjunc_reg;
			charge_details <= dtl_nxt;
			// ok depends on details alone
			charger_ok <= (dtl_nxt == `BSS_DTL_CHARGING)
				|| (dtl_nxt == `BSS_DTL_DONE);
			charger_interrupt <= (thermal_regulation_status_d_r != fl.tjunc_reg)
				|| (temp_bad && !temp_bad_d_r)
				|| (dtl_nxt != charge_details);
		end
	end
endmodule

/* File: verification/bss_host.sv */
// host side model driving the hardware disconnect pin
`timescale 1ns/1ps
module bss_host (
	// request from the bench
	input wire logic drive_on,
	input wire logic drive_lvl,
	// pin towards the device
	output logic pin
);
	// a released pin falls to the board pulldown, never floats
	assign pin = drive_on ? drive_lvl : 1'b0;
endmodule

/* File: verification/bss_supervisor_chk.sv */
// assertions watching the supervisor ports
`timescale 1ns/1ps
module bss_supervisor_chk (
	// clock and reset
	input wire logic clk,
	input wire logic sys_rst,
	// watched inputs
	input wire logic factory_boost_enable,
	input wire logic temp_profile_enable,
	input wire logic hw_battery_disconnect_pin,
	// watched outputs
	input wire logic battery_system_switch,
	input wire logic buck_enable,
	input wire logic charge_active,
	input wire logic boost_active,
	input wire logic thermal_regulation_status,
	input wire logic [3:0] charge_details,
	input wire logic charger_ok,
	input wire logic charger_interrupt
);
	// ----
	// properties
	// ----
	default clocking @(posedge clk); endclocking
	default disable iff (sys_rst);
	// the pin passes two syncs and a register, so allow five samples
	sequence s_pin_hi;
		hw_battery_disconnect_pin[*5];
	endsequence
	sequence s_pin_rise;
		$rose(hw_battery_disconnect_pin) ##1 hw_battery_disconnect_pin[*4];
	endsequence
	property p_pin_open;
		s_pin_hi |-> !battery_system_switch;
	endproperty
	a_pin_open: assert property (p_pin_open)
		else $error("switch closed with pin high");
	property p_pin_chg;
		s_pin_rise |-> !charge_active;
	endproperty
	a_pin_chg: assert property (p_pin_chg)
		else $error("charge kept after pin rise");
	property p_fb_off;
		!factory_boost_enable[*5] |-> !boost_active;
	endproperty
	a_fb_off: assert property (p_fb_off)
		else $error("boost without enable");
	property p_fb_sw;
		boost_active |-> !battery_system_switch;
	endproperty
	a_fb_sw: assert property (p_fb_sw)
		else $error("switch closed in boost");
	property p_ok;
		$stable(charge_details) |->
			charger_ok == (charge_details inside {4'h1, 4'h4});
	endproperty
	a_ok: assert property (p_ok)
		else $error("charger ok not from details");
	property p_susp;
		charge_details == 4'h5 || charge_details == 4'h7 |-> !charge_active;
	endproperty
	a_susp: assert property (p_susp)
		else $error("charging while suspended");
	property p_irq;
		$changed(charge_details) |-> ##[0:1] charger_interrupt;
	endproperty
	a_irq: assert property (p_irq)
		else $error("no interrupt on details change");
	property p_thermal_regulation_status;
		$changed(thermal_regulation_status) |-> ##[0:1] charger_interrupt;
	endproperty
	a_thermal_regulation_status: assert property (p_thermal_regulation_status)
		else $error("no interrupt on thermal loop change");
	property p_seq;
		$fell(buck_enable) |-> !battery_system_switch && !charge_active;
	endproperty
	a_seq: assert property (p_seq)
		else $error("buck off before switch and charge");
	property p_prof;
		!temp_profile_enable[*5] |-> charge_details != 4'h5;
	endproperty
	a_prof: assert property (p_prof)
		else $error("suspend with profile off");
endmodule
bind bss_supervisor bss_supervisor_chk u_chk (.clk, .sys_rst,
	.factory_boost_enable, .temp_profile_enable,
	.hw_battery_disconnect_pin, .battery_system_switch, .buck_enable,
	.charge_active, .boost_active, .thermal_regulation_status,
	.charge_details, .charger_ok, .charger_interrupt);

/* File: verification/bss_supervisor_test.sv */
// self-checking bench for the supervisor
`timescale 1ns/1ps
module bss_supervisor_test import bss_pkg::*;;
	// ----
	// stimulus and outputs
	// ----
	logic clk = 0, sys_rst = 1, soft_battery_disconnect = 0;
	logic factory_boost_enable = 0, temp_profile_enable = 1;
	logic charge_enable = 1, recycle_enable = 0, drv = 0, lvl = 0;
	logic [3:0] mode = 4'h0;
	bss_flags_s cmp_flags = 7'h06;
	logic hw_battery_disconnect_pin, battery_system_switch, buck_enable;
	logic charge_active, boost_active, timer_restart, charger_ok;
	logic thermal_regulation_status, charger_interrupt;
	logic [3:0] charge_details;
	int n_fail = 0, comparisons = 0, cyc = 0, n_irq = 0;
	logic [31:0] seed = 32'h79f4a69c;
	logic [15:0] q[$];
	event smp;
	wire [7:0] got = {battery_system_switch, buck_enable, charge_active,
		boost_active, charge_details};
	always #2.5 clk = ~clk;
	bss_host u_host (.drive_on(drv), .drive_lvl(lvl),
		.pin(hw_battery_disconnect_pin));
	// short counts keep the retry inside the run
	bss_supervisor #(.RETRY_CYC(50), .TIMEOUT_CYC(200)) uut (.clk,
		.sys_rst, .soft_battery_disconnect, .factory_boost_enable,
		.temp_profile_enable, .charge_enable, .recycle_enable, .mode,
		.hw_battery_disconnect_pin, .cmp_flags, .battery_system_switch,
		.buck_enable, .charge_active, .boost_active, .timer_restart,
		.thermal_regulation_status, .charge_details, .charger_ok,
		.charger_interrupt);
	function automatic logic [31:0] xs(logic [31:0] s);
		s ^= s << 13;
		s ^= s >> 17;
		s ^= s << 5;
		return s;
	endfunction
	task automatic wt(int n);
		repeat (n) @(negedge clk);
	endtask
	// masked expectation noted by the driver
	task automatic note(logic [7:0] e, logic [7:0] m);
		q.push_back({m, e});
		->smp;
	endtask
	task automatic cmp(logic [15:0] n);
		comparisons++;
		if (((got ^ n[7:0]) & n[15:8]) !== 8'h00) begin
			n_fail++;
			$display("[ERR] %0t got %h exp %h", $time, got, n[7:0]);
		end
	endtask
	always @(smp) while (q.size() > 0) cmp(q.pop_front());
	// interrupt is a one-cycle pulse, so count it rather than sample it
	always @(posedge clk) if (charger_interrupt === 1'b1) n_irq++;
	// status level bits and pulses counted since the last clear
	task automatic cmp_st(logic t, logic ok, int n);
		comparisons++;
		if (thermal_regulation_status !== t || charger_ok !== ok
			|| n_irq != n) begin
			n_fail++;
			$display("[ERR] %0t status %b%b irq %0d",
				$time, thermal_regulation_status, charger_ok, n_irq);
		end
	endtask
	task automatic wrap_up();
		$display("checks %0d mismatches %0d", comparisons, n_fail);
		if (n_fail == 0 && comparisons > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	// hang guard, well above the planned run
	always @(posedge clk) begin
		cyc++;
		if (cyc == 6000) begin
			n_fail++;
			wrap_up();
		end
	end
	initial begin
		wt(10);
		sys_rst = 0;
		wt(8);
		note(8'he1, 8'hff);
		for (int i = 0; i < 2; i++) begin
			if (i) cmp_flags.hot = 1; else cmp_flags.cold = 1;
			wt(6);
			note(8'h05, 8'h2f);
			cmp_flags.cold = 0;
			cmp_flags.hot = 0;
			wt(6);
			note(8'h21, 8'h2f);
		end
		temp_profile_enable = 0;
		cmp_flags.hot = 1;
		wt(6);
		note(8'h21, 8'h2f);
		temp_profile_enable = 1;
		cmp_flags.thm_grounded = 1;
		wt(6);
		note(8'h21, 8'h2f);
		cmp_flags.thm_grounded = 0;
		cmp_flags.hot = 0;
		cmp_flags.thm_removed = 1;
		wt(6);
		note(8'h07, 8'h2f);
		cmp_flags.thm_removed = 0;
		wt(6);
		$display("thermistor tests done");
		seed = xs(seed);
		recycle_enable = seed[0];
		soft_battery_disconnect = 1;
		wt(8);
		note(8'hc0, 8'he0);
		wt(25);
		note(8'h40, 8'hc0);
		wt(25);
		note(8'h00, 8'hc0);
		cmp_flags.sys_up = 0;
		wt(60);
		soft_battery_disconnect = 0;
		wt(10);
		note(8'hc0, 8'hc0);
		cmp_flags.sys_up = 1;
		wt(6);
		$display("soft disconnect test done");
		drv = 1;
		lvl = 1;
		wt(6);
		note(8'h40, 8'he0);
		drv = 0;
		wt(6);
		note(8'h80, 8'h80);
		mode = 4'h9;
		wt(6);
		note(8'h00, 8'h10);
		factory_boost_enable = 1;
		wt(6);
		note(8'h10, 8'h90);
		mode = 4'h0;
		factory_boost_enable = 0;
		wt(6);
		$display("pin and boost tests done");
		// foldback toggles: one pulse each way, ok left alone
		n_irq = 0;
		cmp_flags.tjunc_reg = 1;
		wt(6);
		cmp_st(1'b1, 1'b1, 1);
		cmp_flags.tjunc_reg = 0;
		wt(6);
		cmp_st(1'b0, 1'b1, 2);
		$display("thermal loop test done");
		wrap_up();
	end
endmodule
